/* File: pcu_pkg.sv */
// Package: register map, field positions and timing constants of the power control unit
package pcu_pkg;

  // ==========================================================
  // Register offsets on the host I/O port space
  localparam logic [15:0] ADDR_LOWER_OUT  = 16'h7072;
  localparam logic [15:0] ADDR_UPPER_OUT  = 16'h7872;
  localparam logic [15:0] ADDR_TIMERS     = 16'h8072;
  localparam logic [15:0] ADDR_INPUTS     = 16'h8872;
  localparam logic [15:0] ADDR_NMI_STATUS = 16'h9072;
  localparam logic [15:0] ADDR_EVENT_EN   = 16'hC872;
  localparam logic [15:0] ADDR_ACT_MASK   = 16'hD872;

  // ==========================================================
  // Lower output bit positions
  localparam int LO_CLK_EN    = 0;
  localparam int LO_PANEL     = 1;
  localparam int LO_BACKLIGHT = 2;
  localparam int LO_GRANT     = 3;
  localparam int LO_ATTN      = 4;
  localparam int LO_PROC_PD   = 5;
  localparam int LO_GATE_A20  = 6;
  localparam int LO_FULL_PD   = 7;

  // ==========================================================
  // Field positions inside the registers
  localparam int UPD_BIT      = 15;
  localparam int LCL_BIT      = 14;
  localparam int AF_LSB       = 8;
  localparam int EI_LSB       = 10;
  localparam int EA_LSB       = 2;
  localparam int BL_LSB       = 8;
  localparam int PANEL_LSB    = 0;
  localparam int EV_W         = 6;
  localparam int ACT_SEL_W    = 3;

  // ==========================================================
  // Reset values and timeout decode
  localparam logic [15:0] TIMERS_RESET  = 16'h0000;
  localparam logic [7:0]  TIMEOUT_OFF   = 8'h00;
  localparam logic [7:0]  TIMEOUT_ON    = 8'hFF;
  localparam logic [7:0]  STEPS_MAX     = 8'hFF;

  // ==========================================================
  // Timing: one timeout step is five seconds
  localparam int STEP_SECONDS = 5;
  localparam int CLK_HZ       = 100_000_000;
  localparam int STEP_CYCLES  = STEP_SECONDS * CLK_HZ;

  // ==========================================================
  // Local access handshake states
  typedef enum logic [2:0] {
    GR_IDLE  = 3'b001,
    GR_HOLD  = 3'b010,
    GR_GRANT = 3'b100
  } pcu_grant_e;

endpackage

/* File: pcu_sync.sv */
// Module: three-flop input synchroniser with agreement filter
module pcu_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================
  // Synchroniser chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Accept a new level only once two stages agree, filtering one-cycle glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

/* File: pcu_power_control.sv */
// Module: power control unit with latched outputs, idle timer and flagged inputs
//
// How it works
// - Upper register low byte drives outputs 8-F
// - Lower outputs carry fixed functions in order
// - Idle timeout clears panel or backlight output
// - Refresh after key/mouse irq restarts timer
// - Mouse irq level chosen by select field
// - One shared idle timer for both timeouts
// - Timeout steps of five seconds, max 1270
// - Backlight field: 00 off, FF on, n*5s
// - Panel field: 00 off, FF on, n*5s
// - Update enable gates external latch update cycles
// - Local request enable makes input 2 request
// - Attention flag set per causing input
// - Status: live when unenabled, latched when enabled
// - Activity mask selects one input as source
// - Enabled input change raises NMI; input 7 on rising edge only
// - Enabled input asserts local attention output
// - Unused enable bits ignored on write
// - NMI flag per input, cleared via enables
// - NMI status upper and low bits read zero
// - External output latch cleared at power-up
// - Grant only after hold acknowledge, then handshake
module pcu_power_control #(
  parameter int STEP_CYCLES = pcu_pkg::STEP_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [15:0] IO_WDATA,
  output logic      [15:0] IO_RDATA,
  input  wire logic [7:0]  MUX_INPUTS,
  input  wire logic        CPU_CLK_EN_IN,
  input  wire logic        PROC_PD_IN,
  input  wire logic        GATE_A20_IN,
  input  wire logic        FULL_PD_IN,
  input  wire logic        KBD_IRQ,
  input  wire logic [3:0]  MOUSE_IRQ,
  input  wire logic [1:0]  MOUSE_IRQ_SEL,
  input  wire logic        REFRESH_TICK,
  input  wire logic        HOLD_ACK,
  input  wire logic        KBC_BYTE_VALID,
  input  wire logic [7:0]  KBC_BYTE,
  output logic      [7:0]  LOWER_OUT,
  output logic      [7:0]  UPPER_OUT,
  output logic      [7:0]  LATCH_DATA,
  output logic             LATCH_LOAD,
  output logic             LATCH_CLEAR,
  output logic             NMI_OUT,
  output logic             HOLD_REQ,
  output logic      [7:0]  KBC_OPCODE,
  output logic             KBC_OPCODE_VALID,
  output logic             ACTIVITY_OUT
);

  localparam int PW = $clog2(STEP_CYCLES + 1);

  logic [15:0]                  timers_q;
  logic                         upd_en_q;
  logic                         lcl_en_q;
  logic [pcu_pkg::EV_W-1:0]     ei_q;
  logic [pcu_pkg::EV_W-1:0]     ea_q;
  logic [pcu_pkg::ACT_SEL_W-1:0] act_sel_q;
  logic [7:0]                   live;
  logic [7:0]                   prev_q;
  logic [pcu_pkg::EV_W-1:0]     ev;
  logic [pcu_pkg::EV_W-1:0]     en_any;
  logic [pcu_pkg::EV_W-1:0]     stat_q;
  logic [pcu_pkg::EV_W-1:0]     nmi_flag_q;
  logic [pcu_pkg::EV_W-1:0]     attn_flag_q;
  logic [PW-1:0]                presc_q;
  logic [7:0]                   steps_q;
  logic                         act_pend_q;
  logic                         activity;
  logic [7:0]                   bl_to;
  logic [7:0]                   pn_to;
  logic                         panel_on;
  logic                         bl_on;
  logic                         req_lvl;
  logic [pcu_pkg::EV_W-1:0]     stat_view;
  logic [7:0]                   ev_by_pin;
  pcu_pkg::pcu_grant_e          gr_q;

  // ==========================================================
  // Input pins cross into the clock domain
  pcu_sync #(
    .W (8)
  ) u_in_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  (MUX_INPUTS),
    .dout (live)
  );

  // Events: input 7 counts rising edges only, inputs 6-2 any transition
  assign ev     = {live[7] & ~prev_q[7], live[6:2] ^ prev_q[6:2]};
  assign en_any = ei_q | ea_q;
  assign req_lvl = lcl_en_q & live[2];

  // Status seen by the host: live level until an enable makes it sticky
  assign stat_view = (en_any & stat_q) | (~en_any & live[7:2]);
  // Events placed at their pin positions, so the activity select indexes them directly
  assign ev_by_pin = {ev, 2'b00};

  // ==========================================================
  // Host register writes; reserved bits are simply not stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      UPPER_OUT <= 8'h00;
      timers_q  <= pcu_pkg::TIMERS_RESET;
      upd_en_q  <= 1'b0;
      lcl_en_q  <= 1'b0;
      ei_q      <= '0;
      ea_q      <= '0;
      act_sel_q <= '0;
    end else if (IO_WR) begin
      unique case (IO_ADDR)
        pcu_pkg::ADDR_UPPER_OUT: UPPER_OUT <= IO_WDATA[7:0];
        pcu_pkg::ADDR_TIMERS:    timers_q  <= IO_WDATA;
        pcu_pkg::ADDR_INPUTS: begin
          // Flag and status bits of this register are read-only
          upd_en_q <= IO_WDATA[pcu_pkg::UPD_BIT];
          lcl_en_q <= IO_WDATA[pcu_pkg::LCL_BIT];
        end
        pcu_pkg::ADDR_EVENT_EN: begin
          // Bits 9-8 and 1-0 are dropped here
          ei_q <= IO_WDATA[pcu_pkg::EI_LSB +: pcu_pkg::EV_W];
          ea_q <= IO_WDATA[pcu_pkg::EA_LSB +: pcu_pkg::EV_W];
        end
        pcu_pkg::ADDR_ACT_MASK:  act_sel_q <= IO_WDATA[pcu_pkg::ACT_SEL_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Host register reads answer one cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      IO_RDATA <= 16'h0000;
    end else if (IO_RD) begin
      unique case (IO_ADDR)
        pcu_pkg::ADDR_LOWER_OUT:  IO_RDATA <= {8'h00, LOWER_OUT};
        pcu_pkg::ADDR_UPPER_OUT:  IO_RDATA <= {8'h00, UPPER_OUT};
        pcu_pkg::ADDR_TIMERS:     IO_RDATA <= timers_q;
        pcu_pkg::ADDR_INPUTS:     IO_RDATA <= {upd_en_q, lcl_en_q, attn_flag_q, stat_view, live[1:0]};
        pcu_pkg::ADDR_NMI_STATUS: IO_RDATA <= {8'h00, nmi_flag_q, 2'b00};
        pcu_pkg::ADDR_EVENT_EN:   IO_RDATA <= {ei_q, 2'b00, ea_q, 2'b00};
        pcu_pkg::ADDR_ACT_MASK:   IO_RDATA <= {13'h0, act_sel_q};
        default:                  IO_RDATA <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Input status and event flags; cleared enables also block new events, so a clear wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      prev_q      <= 8'h00;
      stat_q      <= '0;
      nmi_flag_q  <= '0;
      attn_flag_q <= '0;
    end else begin
      prev_q      <= live;
      stat_q      <= (en_any & (stat_q | ev)) | (~en_any & live[7:2]);
      nmi_flag_q  <= (nmi_flag_q & en_any) | (ev & ei_q);
      attn_flag_q <= (attn_flag_q & en_any) | (ev & ea_q);
    end
  end

  // ==========================================================
  // NMI and activity outputs from the flags and the selected input
  // Select codes 0 and 1 name live-only inputs and pick no source
  always_ff @(posedge CLK) begin
    if (RST) begin
      NMI_OUT      <= 1'b0;
      ACTIVITY_OUT <= 1'b0;
    end else begin
      NMI_OUT      <= |nmi_flag_q;
      ACTIVITY_OUT <= (act_sel_q >= 3'h2) && ev_by_pin[act_sel_q];
    end
  end

  // ==========================================================
  // Shared idle timer; only keyboard and one mouse level count as activity
  assign activity = KBD_IRQ | MOUSE_IRQ[MOUSE_IRQ_SEL];

  always_ff @(posedge CLK) begin
    if (RST) begin
      act_pend_q <= 1'b0;
      presc_q    <= '0;
      steps_q    <= 8'h00;
    end else begin
      // Activity arriving on the refresh tick itself stays pending for the next one
      act_pend_q <= (act_pend_q & ~REFRESH_TICK) | activity;
      if (REFRESH_TICK && act_pend_q) begin
        presc_q <= '0;
        steps_q <= 8'h00;
      end else if (presc_q == PW'(STEP_CYCLES - 1)) begin
        presc_q <= '0;
        if (steps_q != pcu_pkg::STEPS_MAX) begin
          steps_q <= steps_q + 8'h01;
        end
      end else begin
        presc_q <= presc_q + PW'(1);
      end
    end
  end

  // Timeout decode: zero forces off, all-ones forces on, else n steps
  // The step count saturates, so a long idle period never wraps back to on
  assign bl_to    = timers_q[pcu_pkg::BL_LSB +: 8];
  assign pn_to    = timers_q[pcu_pkg::PANEL_LSB +: 8];
  assign bl_on    = (bl_to == pcu_pkg::TIMEOUT_ON) || ((bl_to != pcu_pkg::TIMEOUT_OFF) && (steps_q < bl_to));
  assign panel_on = (pn_to == pcu_pkg::TIMEOUT_ON) || ((pn_to != pcu_pkg::TIMEOUT_OFF) && (steps_q < pn_to));

  // ==========================================================
  // Local register access handshake with the keyboard controller
  always_ff @(posedge CLK) begin
    if (RST) begin
      gr_q     <= pcu_pkg::GR_IDLE;
      HOLD_REQ <= 1'b0;
    end else begin
      unique case (gr_q)
        pcu_pkg::GR_IDLE: begin
          if (req_lvl) begin
            gr_q     <= pcu_pkg::GR_HOLD;
            HOLD_REQ <= 1'b1;
          end
        end
        pcu_pkg::GR_HOLD: begin
          // Grant waits for the processor to yield the bus
          if (HOLD_ACK) begin
            gr_q <= pcu_pkg::GR_GRANT;
          end
        end
        pcu_pkg::GR_GRANT: begin
          // Only the request falling ends an access; a falling hold acknowledge does not
          if (!req_lvl) begin
            gr_q     <= pcu_pkg::GR_IDLE;
            HOLD_REQ <= 1'b0;
          end
        end
        default: begin
          gr_q     <= pcu_pkg::GR_IDLE;
          HOLD_REQ <= 1'b0;
        end
      endcase
    end
  end

  // Opcode byte captured while granted
  always_ff @(posedge CLK) begin
    if (RST) begin
      KBC_OPCODE       <= 8'h00;
      KBC_OPCODE_VALID <= 1'b0;
    end else begin
      KBC_OPCODE_VALID <= (gr_q == pcu_pkg::GR_GRANT) && KBC_BYTE_VALID;
      if ((gr_q == pcu_pkg::GR_GRANT) && KBC_BYTE_VALID) begin
        KBC_OPCODE <= KBC_BYTE;
      end
    end
  end

  // ==========================================================
  // Lower outputs in fixed order
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOWER_OUT <= 8'h00;
    end else begin
      LOWER_OUT[pcu_pkg::LO_CLK_EN]    <= CPU_CLK_EN_IN;
      LOWER_OUT[pcu_pkg::LO_PANEL]     <= panel_on;
      LOWER_OUT[pcu_pkg::LO_BACKLIGHT] <= bl_on;
      LOWER_OUT[pcu_pkg::LO_GRANT]     <= (gr_q == pcu_pkg::GR_GRANT);
      LOWER_OUT[pcu_pkg::LO_ATTN]      <= |(attn_flag_q & ea_q);
      LOWER_OUT[pcu_pkg::LO_PROC_PD]   <= PROC_PD_IN;
      LOWER_OUT[pcu_pkg::LO_GATE_A20]  <= GATE_A20_IN;
      LOWER_OUT[pcu_pkg::LO_FULL_PD]   <= FULL_PD_IN;
    end
  end

  // ==========================================================
  // External latch: cleared during reset, reloaded when outputs differ while update is enabled and no load went out the cycle before
  always_ff @(posedge CLK) begin
    if (RST) begin
      LATCH_CLEAR <= 1'b1;
      LATCH_DATA  <= 8'h00;
      LATCH_LOAD  <= 1'b0;
    end else begin
      LATCH_CLEAR <= 1'b0;
      // Comparing against the latch copy means a change made while disabled still lands later
      // A load is never issued on back-to-back cycles, so the latch sees one clean strobe
      LATCH_LOAD  <= upd_en_q && (LOWER_OUT != LATCH_DATA) && !LATCH_LOAD;
      if (upd_en_q && (LOWER_OUT != LATCH_DATA) && !LATCH_LOAD) begin
        LATCH_DATA <= LOWER_OUT;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_upper_write: assert property (IO_WR && IO_ADDR == pcu_pkg::ADDR_UPPER_OUT
    |=> UPPER_OUT == $past(IO_WDATA[7:0]))
    else $error("upper outputs did not take written byte");
  a_backlight_decode: assert property (bl_to == pcu_pkg::TIMEOUT_ON |=> LOWER_OUT[pcu_pkg::LO_BACKLIGHT])
    else $error("backlight off with always-on timeout");
  a_panel_off_zero: assert property (pn_to == pcu_pkg::TIMEOUT_OFF |=> !LOWER_OUT[pcu_pkg::LO_PANEL])
    else $error("panel on with zero timeout");
  a_timer_restart: assert property (REFRESH_TICK && act_pend_q |=> steps_q == 8'h00 ##0 presc_q == '0)
    else $error("timer not restarted after activity");
  a_no_update_dis: assert property (!upd_en_q |=> !LATCH_LOAD)
    else $error("latch update while disabled");
  a_update_change: assert property (upd_en_q && !LATCH_LOAD && LOWER_OUT != LATCH_DATA
    |=> LATCH_LOAD ##0 LATCH_DATA == $past(LOWER_OUT))
    else $error("missed latch update");
  a_nmi_on_event: assert property (|(ev & ei_q) |=> ##1 NMI_OUT)
    else $error("enabled event gave no NMI");
  a_flags_clear: assert property (ei_q == '0 && ea_q == '0 |=> nmi_flag_q == '0 ##0 attn_flag_q == '0)
    else $error("flags survive cleared enables");
  a_attn_output: assert property (|(attn_flag_q & ea_q) |=> LOWER_OUT[pcu_pkg::LO_ATTN])
    else $error("attention output not asserted");
  a_live_status: assert property (IO_RD && IO_ADDR == pcu_pkg::ADDR_INPUTS && en_any == '0
    |=> IO_RDATA[7:0] == $past(live))
    else $error("unenabled status not live");
  a_nmi_rsvd_zero: assert property (IO_RD && IO_ADDR == pcu_pkg::ADDR_NMI_STATUS
    |=> IO_RDATA[15:8] == 8'h00 && IO_RDATA[1:0] == 2'b00)
    else $error("reserved NMI status bits nonzero");
  a_grant_hold: assert property ($rose(LOWER_OUT[pcu_pkg::LO_GRANT]) |-> HOLD_REQ && $past(HOLD_ACK, 2))
    else $error("grant before hold acknowledge");
  a_panel_timeout: assert property (pn_to != pcu_pkg::TIMEOUT_ON && steps_q >= pn_to
    |=> !LOWER_OUT[pcu_pkg::LO_PANEL])
    else $error("panel still on after timeout");
  a_no_local_dis: assert property (!lcl_en_q && gr_q == pcu_pkg::GR_IDLE |=> !HOLD_REQ)
    else $error("hold request while local access disabled");

  // Covers for the main scenarios
  c_grant_seen:  cover property (gr_q == pcu_pkg::GR_GRANT ##[1:50] gr_q == pcu_pkg::GR_IDLE);
  c_panel_off:   cover property ($fell(LOWER_OUT[pcu_pkg::LO_PANEL]));
  c_nmi_raised:  cover property ($rose(NMI_OUT));
  c_latch_load:  cover property (LATCH_LOAD);
  c_backlight_off: cover property ($fell(LOWER_OUT[pcu_pkg::LO_BACKLIGHT]));

endmodule

/* File: pcu_far_model.sv */
// Far-side model of the power control unit: external output latch and processor hold responder
module pcu_far_model (
  input  wire logic       clk,
  input  wire logic       hold_req,
  input  wire logic [7:0] latch_data,
  input  wire logic       latch_load,
  input  wire logic       latch_clear,
  input  wire logic [3:0] ack_delay,
  output logic            hold_ack,
  output logic      [7:0] latch_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // ==========================================================
  // Octal latch: held clear while clear is high, loads only on an update pulse
  always_ff @(posedge clk) begin
    if (latch_clear) latch_q <= 8'h00;
    else if (latch_load) latch_q <= latch_data;
  end
  // ==========================================================
  // Processor grants hold after a chosen delay, so slow answers are exercised too
  always_ff @(posedge clk) begin
    if (!hold_req) begin
      hold_ack <= 1'b0;
      wait_q   <= ack_delay;
    end else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    else hold_ack <= 1'b1;
  end
endmodule

/* File: test_power_control_io_unit.sv */
// Self-checking testbench of the power control unit
module test_power_control_io_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 10; // Short timeout step keeps the run brief
  logic        clk, rst, io_wr, io_rd, clk_en_in, proc_pd_in, a20_in, full_pd_in;
  logic        kbd_irq, refresh, hold_ack, kbc_valid, latch_load, latch_clear, nmi_out;
  logic        hold_req, kbc_opcode_valid, activity_out, hit;
  logic [15:0] io_addr, io_wdata, io_rdata, v, r;
  logic [7:0]  mux_in, kbc_byte, lower_out, upper_out, latch_data, kbc_opcode, latch_q, got_op;
  logic [3:0]  mouse_irq, ack_delay;
  logic [1:0]  mouse_sel;
  int          err_total, comparisons, seed;

  pcu_power_control #(.STEP_CYCLES(STEP)) dut_u (
    .CLK(clk), .RST(rst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata),
    .IO_RDATA(io_rdata), .MUX_INPUTS(mux_in), .CPU_CLK_EN_IN(clk_en_in), .PROC_PD_IN(proc_pd_in),
    .GATE_A20_IN(a20_in), .FULL_PD_IN(full_pd_in), .KBD_IRQ(kbd_irq), .MOUSE_IRQ(mouse_irq),
    .MOUSE_IRQ_SEL(mouse_sel), .REFRESH_TICK(refresh), .HOLD_ACK(hold_ack), .KBC_BYTE_VALID(kbc_valid),
    .KBC_BYTE(kbc_byte), .LOWER_OUT(lower_out), .UPPER_OUT(upper_out), .LATCH_DATA(latch_data),
    .LATCH_LOAD(latch_load), .LATCH_CLEAR(latch_clear), .NMI_OUT(nmi_out), .HOLD_REQ(hold_req),
    .KBC_OPCODE(kbc_opcode), .KBC_OPCODE_VALID(kbc_opcode_valid), .ACTIVITY_OUT(activity_out));

  pcu_far_model far_u (
    .clk(clk), .hold_req(hold_req), .latch_data(latch_data), .latch_load(latch_load),
    .latch_clear(latch_clear), .ack_delay(ack_delay), .hold_ack(hold_ack), .latch_q(latch_q));

  // ==========================================================
  // Clock and watchdog; the watchdog span is far beyond the expected run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200_000;
    err_total++;
    report_and_stop();
  end

  // ==========================================================
  // Checking, register access and expectation helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  // Read data lands one edge after the strobe edge, so sample a full cycle later
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    @(negedge clk);
    d = io_rdata;
  endtask
  // Activity pulse on keyboard or mouse lines, then one refresh cycle
  task automatic act(input logic k, input logic [3:0] m);
    kbd_irq   = k;
    mouse_irq = m;
    @(negedge clk);
    kbd_irq   = 1'b0;
    mouse_irq = 4'h0;
    refresh   = 1'b1;
    @(negedge clk);
    refresh = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  function automatic logic [15:0] en_exp(input logic [15:0] d);
    return d & 16'hFCFC;
  endfunction
  function automatic logic [15:0] low_exp(input logic [3:0] f);
    return {8'h00, f[3], f[2], f[1], 4'h0, f[0]};
  endfunction
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h7F5F;
    {rst, io_wr, io_rd, clk_en_in, proc_pd_in, a20_in, full_pd_in, kbd_irq, refresh, kbc_valid} = 10'h3FF & 10'h200;
    {io_addr, io_wdata, mux_in, kbc_byte, mouse_irq, mouse_sel} = '0;
    ack_delay   = 4'h3;
    err_total   = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    chk({15'h0, latch_clear}, 16'h0001);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk({8'h00, latch_q}, 16'h0000);
    rd(pcu_pkg::ADDR_TIMERS, r);
    chk(r, pcu_pkg::TIMERS_RESET);
    wr(pcu_pkg::ADDR_NMI_STATUS, 16'hFFFF);
    rd(pcu_pkg::ADDR_NMI_STATUS, r);
    chk(r, 16'h0000);
    // Random upper outputs and enable words with unused bits set
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(pcu_pkg::ADDR_UPPER_OUT, v);
      rd(pcu_pkg::ADDR_UPPER_OUT, r);
      chk(r, {8'h00, v[7:0]});
      chk({8'h00, upper_out}, {8'h00, v[7:0]});
      v = $random(seed);
      wr(pcu_pkg::ADDR_EVENT_EN, v);
      rd(pcu_pkg::ADDR_EVENT_EN, r);
      chk(r, en_exp(v));
    end
    wr(pcu_pkg::ADDR_EVENT_EN, 16'h0000);
    // Fixed-function lower outputs; timer fields at zero keep panel and backlight off
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      {full_pd_in, a20_in, proc_pd_in, clk_en_in} = v[3:0];
      repeat (3) @(negedge clk);
      rd(pcu_pkg::ADDR_LOWER_OUT, r);
      chk(r & 16'h00E7, low_exp(v[3:0]));
    end
    chk({8'h00, latch_q}, 16'h0000);
    wr(pcu_pkg::ADDR_INPUTS, 16'h8000);
    clk_en_in = ~clk_en_in;
    repeat (4) @(negedge clk);
    chk({8'h00, latch_q}, low_exp({v[3:1], clk_en_in}));
    // Shared idle timer: panel two steps, backlight forced on; still on after one step
    wr(pcu_pkg::ADDR_TIMERS, 16'hFF02);
    act(1'b1, 4'h0);
    chk({14'h0, lower_out[2:1]}, 16'h0003);
    repeat (STEP) @(negedge clk);
    chk({14'h0, lower_out[2:1]}, 16'h0003);
    repeat (2 * STEP + 5) @(negedge clk);
    chk({14'h0, lower_out[2:1]}, 16'h0002);
    wr(pcu_pkg::ADDR_TIMERS, 16'h0100);
    mouse_sel = 2'h2;
    repeat (3) @(negedge clk);
    act(1'b0, 4'h1);
    chk({14'h0, lower_out[2:1]}, 16'h0000);
    act(1'b0, 4'h4);
    chk({14'h0, lower_out[2:1]}, 16'h0002);
    // Input events: NMI on input 7 rising, attention on input 3
    wr(pcu_pkg::ADDR_EVENT_EN, 16'h8008);
    mux_in = 8'h82;
    repeat (10) @(negedge clk);
    chk({15'h0, nmi_out}, 16'h0001);
    rd(pcu_pkg::ADDR_NMI_STATUS, r);
    chk(r, 16'h0080);
    mux_in = 8'h8A;
    repeat (10) @(negedge clk);
    mux_in = 8'h82;
    repeat (10) @(negedge clk);
    chk({15'h0, lower_out[4]}, 16'h0001);
    rd(pcu_pkg::ADDR_INPUTS, r);
    chk(r, 16'h828A);
    wr(pcu_pkg::ADDR_EVENT_EN, 16'h0000);
    repeat (3) @(negedge clk);
    chk({14'h0, nmi_out, lower_out[4]}, 16'h0000);
    rd(pcu_pkg::ADDR_NMI_STATUS, r);
    chk(r, 16'h0000);
    rd(pcu_pkg::ADDR_INPUTS, r);
    chk(r, 16'h8082);
    // Activity source selection on input 5
    wr(pcu_pkg::ADDR_ACT_MASK, 16'h0005);
    hit = 1'b0;
    mux_in[5] = 1'b1;
    repeat (10) begin
      @(negedge clk);
      if (activity_out === 1'b1) hit = 1'b1;
    end
    chk({15'h0, hit}, 16'h0001);
    // Local access: ignored while disabled, then the full handshake
    mux_in[2] = 1'b1;
    repeat (10) @(negedge clk);
    chk({15'h0, hold_req}, 16'h0000);
    ack_delay = 4'($unsigned($random(seed)) % 6);
    wr(pcu_pkg::ADDR_INPUTS, 16'hC000);
    for (int i = 0; i < 20 && hold_req !== 1'b1; i++) @(negedge clk);
    chk({14'h0, hold_req, lower_out[3]}, 16'h0002);
    for (int i = 0; i < 30 && lower_out[3] !== 1'b1; i++) @(negedge clk);
    chk({15'h0, lower_out[3]}, 16'h0001);
    kbc_byte  = $random(seed);
    kbc_valid = 1'b1;
    @(negedge clk);
    kbc_valid = 1'b0;
    got_op    = 8'h00;
    repeat (3) begin
      if (kbc_opcode_valid === 1'b1) got_op = kbc_opcode;
      @(negedge clk);
    end
    chk({8'h00, got_op}, {8'h00, kbc_byte});
    mux_in[2] = 1'b0;
    for (int i = 0; i < 20 && lower_out[3] !== 1'b0; i++) @(negedge clk);
    chk({14'h0, hold_req, lower_out[3]}, 16'h0000);
    report_and_stop();
  end
endmodule
